// ===== hdl/adc_clock_divider.sv
`timescale 1ns/1ps
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  logic [6:0] count;
  logic [6:0] limit;

  // tick period minus one, in system clocks, for each clock code
  function automatic logic [6:0] div_of(input logic [2:0] s);
    case (s)
      3'h0: div_of = 7'h01;
      3'h1: div_of = 7'h07;
      3'h2: div_of = 7'h1F;
      3'h4: div_of = 7'h03;
      3'h5: div_of = 7'h0F;
      3'h6: div_of = 7'h3F;
      default: div_of = 7'(RC_DIV - 1);
    endcase
  endfunction : div_of

  assign limit = div_of(sel_i);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= 7'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count <= 7'h00;
      tick_o <= 1'b0;
    end else if (count >= limit) begin
      count <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick_o <= 1'b0;
    end
  end
endmodule : adc_clock_divider

// ===== hdl/adc_control_and_result_regs.sv
`timescale 1ns/1ps
// Contract
// - five-bit positive channel code drives mux
// - writing start bit launches conversion
// - hardware clears start bit when done
// - power bit enables converter, off shuts down
// - reserved channels give arbitrary result
// - two-bit special trigger source select
// - two-bit positive reference select
// - one bit negative reference select
// - three-bit negative channel, zero single-ended
// - justify bit selects right or left
// - acquisition delay code to clock periods
// - three-bit conversion clock select
// - RC clock adds one instruction wait
// - result and sign loaded at completion
// - left format byte layout with sign
// - right format high byte sign, bits
// - right format low byte bits 7-0
// - four sign copies equal result sign
// - result bytes plain storage when off
// - flag set as start bit clears
// - reset clears control, aborts conversion
module adc_control_and_result_regs
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_i,
  input wire logic result_negative_i,
  output logic [4:0] positive_channel_sel_o,
  output logic [2:0] negative_channel_sel_o,
  output logic [1:0] positive_reference_sel_o,
  output logic negative_reference_sel_o,
  output logic [1:0] special_trigger_sel_o,
  output logic converter_power_on_o,
  output logic sample_o,
  output logic [11:0] trial_code_o,
  output logic converter_irq_flag_o
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] adc_channel_power_ctrl;
  logic [7:0] adc_reference_trigger_cfg;
  logic [7:0] adc_timing_format_cfg;
  logic [7:0] adc_result_high;
  logic [7:0] adc_result_low;
  logic converter_irq_flag;
  conv_state_t state;
  logic [4:0] wait_count;
  logic [3:0] bit_index;
  logic [11:0] sar;
  logic tick;
  logic done;
  logic have_aw, have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic start_req;

  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    case (code)
      3'h0: acq_periods = 5'd0;
      3'h1: acq_periods = 5'd2;
      3'h2: acq_periods = 5'd4;
      3'h3: acq_periods = 5'd6;
      3'h4: acq_periods = 5'd8;
      3'h5: acq_periods = 5'd12;
      3'h6: acq_periods = 5'd16;
      default: acq_periods = 5'd20;
    endcase
  endfunction : acq_periods

  function automatic logic [15:0] pack_result(input logic [11:0] r, input logic s,
                                              input logic right);
    if (right) begin
      pack_result = {{4{s}}, r};
    end else begin
      pack_result = {r, {4{s}}};
    end
  endfunction : pack_result

  wire logic power_on = adc_channel_power_ctrl[POWER_BIT];
  wire logic busy = adc_channel_power_ctrl[START_BIT];
  wire logic [2:0] clk_code = adc_timing_format_cfg[CLK_MSB:CLK_LSB];
  wire logic rc_clock = (clk_code == CLK_RC_A) || (clk_code == CLK_RC_B);
  wire logic [15:0] packed_result =
    pack_result(sar, result_negative_i, adc_timing_format_cfg[JUSTIFY_BIT]);

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  assign wr_fire = have_aw && have_w && !s_axi_bvalid;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !have_w && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > ADDR_STATUS) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // only the low byte lane carries register data
  wire logic wr_byte = wr_fire && w_strb[0];
  assign start_req = wr_byte && aw_addr == ADDR_CHANNEL_POWER && w_data[START_BIT]
                     && w_data[POWER_BIT] && !busy;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      adc_channel_power_ctrl <= CTRL_RESET;
      adc_reference_trigger_cfg <= CTRL_RESET;
      adc_timing_format_cfg <= CTRL_RESET;
    end else begin
      if (wr_byte && aw_addr == ADDR_CHANNEL_POWER) begin
        adc_channel_power_ctrl[CHAN_MSB:CHAN_LSB] <= w_data[CHAN_MSB:CHAN_LSB];
        adc_channel_power_ctrl[POWER_BIT] <= w_data[POWER_BIT];
        if (start_req) begin
          adc_channel_power_ctrl[START_BIT] <= 1'b1;
        end
      end
      if ((done || !power_on) && !start_req) begin
        adc_channel_power_ctrl[START_BIT] <= 1'b0;
      end
      if (wr_byte && aw_addr == ADDR_REFERENCE_TRIG) begin
        adc_reference_trigger_cfg <= w_data[7:0];
      end
      if (wr_byte && aw_addr == ADDR_TIMING_FORMAT) begin
        adc_timing_format_cfg <= w_data[7:0] & TIMING_WMASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  adc_clock_divider adc_clock_divider_i (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(state == ST_ACQUIRE || state == ST_CONVERT),
    .sel_i(clk_code),
    .tick_o(tick)
  );

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      wait_count <= 5'd0;
      bit_index <= 4'd0;
      sar <= 12'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!power_on && !start_req) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start_req) begin
              state <= rc_clock ? ST_RC_WAIT : ST_ACQUIRE;
              wait_count <= rc_clock ? 5'(INSTR_CYCLES)
                : acq_periods(adc_timing_format_cfg[ACQ_MSB:ACQ_LSB]);
            end
          end
          ST_RC_WAIT: begin
            // lets a sleep take effect before the converter clock starts
            if (wait_count <= 5'd1) begin
              state <= ST_ACQUIRE;
              wait_count <= acq_periods(adc_timing_format_cfg[ACQ_MSB:ACQ_LSB]);
            end else begin
              wait_count <= wait_count - 5'd1;
            end
          end
          ST_ACQUIRE: begin
            if (wait_count == 5'd0 || (tick && wait_count == 5'd1)) begin
              state <= ST_CONVERT;
              wait_count <= 5'd0;
              bit_index <= 4'(CONV_BITS - 1);
              sar <= 12'h800;
            end else if (tick) begin
              wait_count <= wait_count - 5'd1;
            end
          end
          ST_CONVERT: begin
            if (tick) begin
              // comparator high keeps the trial bit; reserved codes give junk
              sar[bit_index] <= comparator_i;
              if (bit_index == 4'd0) begin
                state <= ST_IDLE;
                done <= 1'b1;
              end else begin
                bit_index <= bit_index - 4'd1;
                sar[bit_index - 4'd1] <= 1'b1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // result pair and flag
  // ---------------------------------------------------------------
  // result bytes keep contents over reset, hence no reset branch
  always_ff @(posedge ref_clk_i) begin
    if (done) begin
      // completion wins over a same-cycle software write
      adc_result_high <= packed_result[15:8];
      adc_result_low <= packed_result[7:0];
    end else if (wr_byte && aw_addr == ADDR_RESULT_HIGH) begin
      adc_result_high <= w_data[7:0];
    end else if (wr_byte && aw_addr == ADDR_RESULT_LOW) begin
      adc_result_low <= w_data[7:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      converter_irq_flag <= 1'b0;
    end else if (done) begin
      converter_irq_flag <= 1'b1;
    end else if (wr_byte && aw_addr == ADDR_STATUS && !w_data[IRQ_FLAG_BIT]) begin
      converter_irq_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read path and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          ADDR_CHANNEL_POWER: s_axi_rdata <= {24'h00_0000, adc_channel_power_ctrl};
          ADDR_REFERENCE_TRIG: s_axi_rdata <= {24'h00_0000, adc_reference_trigger_cfg};
          ADDR_TIMING_FORMAT: s_axi_rdata <= {24'h00_0000, adc_timing_format_cfg};
          ADDR_RESULT_HIGH: s_axi_rdata <= {24'h00_0000, adc_result_high};
          ADDR_RESULT_LOW: s_axi_rdata <= {24'h00_0000, adc_result_low};
          ADDR_STATUS: s_axi_rdata <= 32'(converter_irq_flag) << IRQ_FLAG_BIT;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      positive_channel_sel_o <= 5'h00;
      negative_channel_sel_o <= 3'h0;
      positive_reference_sel_o <= 2'h0;
      negative_reference_sel_o <= 1'b0;
      special_trigger_sel_o <= 2'h0;
      converter_power_on_o <= 1'b0;
      sample_o <= 1'b0;
      trial_code_o <= 12'h000;
      converter_irq_flag_o <= 1'b0;
    end else begin
      positive_channel_sel_o <= adc_channel_power_ctrl[CHAN_MSB:CHAN_LSB];
      negative_channel_sel_o <= adc_reference_trigger_cfg[NCHAN_MSB:NCHAN_LSB];
      positive_reference_sel_o <= adc_reference_trigger_cfg[VREFP_MSB:VREFP_LSB];
      negative_reference_sel_o <= adc_reference_trigger_cfg[VREFN_BIT];
      special_trigger_sel_o <= adc_reference_trigger_cfg[TRIG_MSB:TRIG_LSB];
      converter_power_on_o <= power_on;
      sample_o <= (state == ST_ACQUIRE) || (state == ST_RC_WAIT);
      trial_code_o <= sar;
      converter_irq_flag_o <= converter_irq_flag;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_start_sets_busy: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    start_req |=> busy) else $error("start did not set busy");
  a_done_clears_busy: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    done |=> !busy) else $error("busy not cleared at done");
  a_done_sets_flag: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    done |=> converter_irq_flag) else $error("flag not set at done");
  a_off_is_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !power_on && !start_req |=> state == ST_IDLE) else $error("converter active while off");
  a_result_loaded: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    done |=> {adc_result_high, adc_result_low} == $past(packed_result))
    else $error("result not loaded");
  a_sign_copies: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    done && adc_timing_format_cfg[JUSTIFY_BIT] |=> adc_result_high[7:4] == {4{$past(result_negative_i)}})
    else $error("sign copies wrong");
  a_zero_acq: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state == ST_ACQUIRE && wait_count == 5'd0 && power_on |=> state == ST_CONVERT)
    else $error("acquisition overran");
  a_rc_wait: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state == ST_IDLE && start_req && rc_clock && power_on |=> state == ST_RC_WAIT)
    else $error("rc wait skipped");
  a_ctrl_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    1'b1 |=> special_trigger_sel_o == $past(adc_reference_trigger_cfg[TRIG_MSB:TRIG_LSB]))
    else $error("trigger select stale");
  c_conversion: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) done);
  c_rc_path: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) state == ST_RC_WAIT);
  c_right: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    done && adc_timing_format_cfg[JUSTIFY_BIT]);
endmodule : adc_control_and_result_regs

// ===== hdl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CHANNEL_POWER = 8'h00;
  localparam logic [7:0] ADDR_REFERENCE_TRIG = 8'h04;
  localparam logic [7:0] ADDR_TIMING_FORMAT = 8'h08;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POWER_BIT = 0;
  localparam int START_BIT = 1;
  localparam int CHAN_LSB = 2;
  localparam int CHAN_MSB = 6;
  localparam int TRIG_LSB = 6;
  localparam int TRIG_MSB = 7;
  localparam int VREFP_LSB = 4;
  localparam int VREFP_MSB = 5;
  localparam int VREFN_BIT = 3;
  localparam int NCHAN_LSB = 0;
  localparam int NCHAN_MSB = 2;
  localparam int JUSTIFY_BIT = 7;
  localparam int ACQ_LSB = 3;
  localparam int ACQ_MSB = 5;
  localparam int CLK_LSB = 0;
  localparam int CLK_MSB = 2;
  localparam int IRQ_FLAG_BIT = 6;
  localparam logic [7:0] CHAN_WMASK = 8'h7D;
  localparam logic [7:0] TIMING_WMASK = 8'hBF;
  // ---------------------------------------------------------------
  // codes and timing
  // ---------------------------------------------------------------
  localparam logic [4:0] CHAN_LAST_EXTERNAL = 5'h17;
  localparam logic [4:0] CHAN_CHARGE_TIME = 5'h1C;
  localparam logic [2:0] CLK_RC_A = 3'h3;
  localparam logic [2:0] CLK_RC_B = 3'h7;
  localparam int CONV_BITS = 12;
  localparam int RC_DIV = 4;
  localparam int INSTR_CYCLE_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {ST_IDLE, ST_RC_WAIT, ST_ACQUIRE, ST_CONVERT} conv_state_t;
endpackage : adc_ctrl_pkg

// ===== test/adc_control_and_result_regs_bench.sv
`timescale 1ns/1ps
module adc_control_and_result_regs_bench;
  import adc_ctrl_pkg::*;
  logic ref_clk_i, sys_rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, positive_reference_sel_o, special_trigger_sel_o;
  logic comparator_i, result_negative_i, negative_reference_sel_o, converter_power_on_o;
  logic sample_o, converter_irq_flag_o, neg, counting;
  logic [4:0] positive_channel_sel_o;
  logic [2:0] negative_channel_sel_o;
  logic [11:0] trial_code_o, target;
  logic [4:0] chans[4] = '{5'h00, 5'h17, 5'h1C, 5'h1F};
  int tick_tab[8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};
  int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int num_errors = 0;
  int total_checks = 0;
  int samp = 0;

  adc_control_and_result_regs adc_control_and_result_regs_i (.ref_clk_i, .sys_rst_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .comparator_i, .result_negative_i,
    .positive_channel_sel_o, .negative_channel_sel_o, .positive_reference_sel_o,
    .negative_reference_sel_o, .special_trigger_sel_o, .converter_power_on_o,
    .sample_o, .trial_code_o, .converter_irq_flag_o);

  sar_core_model sar_core_model_i (.ref_clk_i, .power_i(converter_power_on_o),
    .trial_i(trial_code_o), .target_i(target), .negative_i(neg),
    .comparator_o(comparator_i), .result_negative_o(result_negative_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (counting && sample_o === 1'b1) samp++;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit b;
    int n;
    b = 0;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= 32'(d);
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 200) begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        b = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!b) num_errors++;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    bit b;
    int n;
    b = 0;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b && n < 200) begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        b = 1;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!b) num_errors++;
  endtask : rd_reg

  // ---------------------------------------------------------------
  // one conversion, start to result
  // ---------------------------------------------------------------
  task automatic convert(input logic [7:0] tf, input logic [11:0] t, input logic s);
    int tick, acq, n;
    logic [15:0] res;
    tick = tick_tab[tf[2:0]];
    acq = acq_tab[tf[5:3]] * tick;
    if (tf[2:0] == CLK_RC_A || tf[2:0] == CLK_RC_B) acq = acq + INSTR_CYCLES;
    target = t;
    neg = s;
    wr(ADDR_TIMING_FORMAT, tf);
    samp = 0;
    counting = 1'b1;
    wr(ADDR_CHANNEL_POWER, 8'h0F);
    rd_reg(ADDR_CHANNEL_POWER);
    check("busy", rd, 32'h0000_000F);
    wr(ADDR_RESULT_HIGH, 8'h5A);
    n = 0;
    do begin
      rd_reg(ADDR_CHANNEL_POWER);
      n++;
    end while (rd[START_BIT] === 1'b1 && n < 3000);
    counting = 1'b0;
    check("done", rd, 32'h0000_000D);
    check("trial", 32'(trial_code_o), 32'(t));
    check("flag", 32'(converter_irq_flag_o), 1);
    // sample window may run up to one tick long, tick phase restarts at each acquisition
    check("acq", 32'(samp >= acq && samp <= acq + tick + 2), 1);
    res = tf[JUSTIFY_BIT] ? {{4{s}}, t} : {t, {4{s}}};
    rd_reg(ADDR_RESULT_HIGH);
    check("res_hi", rd, 32'(res[15:8]));
    rd_reg(ADDR_RESULT_LOW);
    check("res_lo", rd, 32'(res[7:0]));
    wr(ADDR_STATUS, 8'h00);
    repeat (2 * tick) @(posedge ref_clk_i);
    check("flag_clr", 32'(converter_irq_flag_o), 0);
  endtask : convert

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, target, neg, counting} = '0;
    s_axi_wstrb = 4'hF;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_reg(i == 3 ? ADDR_STATUS : 8'(4 * i));
      check("rst_val", rd, 0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_REFERENCE_TRIG, 8'(i * 8'h55));
      rd_reg(ADDR_REFERENCE_TRIG);
      check("ref_trig", rd, 32'(8'(i * 8'h55)));
      check("cfg_pins", {special_trigger_sel_o, positive_reference_sel_o,
        negative_reference_sel_o, negative_channel_sel_o}, 32'(8'(i * 8'h55)));
      wr(ADDR_CHANNEL_POWER, {1'b1, chans[i], 2'b10});
      rd_reg(ADDR_CHANNEL_POWER);
      check("chan", rd, 32'({1'b0, chans[i], 2'b00}));
      check("chan_pin", 32'(positive_channel_sel_o), 32'(chans[i]));
    end
    wr(ADDR_TIMING_FORMAT, 8'hFF);
    rd_reg(ADDR_TIMING_FORMAT);
    check("timing", rd, 32'h0000_00BF);
    wr(ADDR_RESULT_HIGH, 8'hA5);
    wr(ADDR_RESULT_LOW, 8'h3C);
    rd_reg(ADDR_RESULT_HIGH);
    check("store_hi", rd, 32'h0000_00A5);
    rd_reg(ADDR_RESULT_LOW);
    check("store_lo", rd, 32'h0000_003C);
    rd_reg(8'h18);
    check("rresp", 32'(resp), 2); // unmapped read
    wr(8'h20, 8'h01);
    check("bresp", 32'(resp), 2); // unmapped write
    for (int i = 0; i < 8; i++)
      convert(8'((i % 2) * 128 + i * 8 + i), i == 7 ? 12'hFFF : 12'(i * 12'h2B5), i[1]);
    // abort by power off in mid acquisition
    wr(ADDR_TIMING_FORMAT, 8'h3E);
    wr(ADDR_CHANNEL_POWER, 8'h03);
    repeat (50) @(posedge ref_clk_i);
    wr(ADDR_CHANNEL_POWER, 8'h00);
    rd_reg(ADDR_CHANNEL_POWER);
    check("abort", rd, 0);
    check("pwr_pin", 32'({converter_power_on_o, converter_irq_flag_o}), 0);
    // reset in mid acquisition keeps the high result byte
    wr(ADDR_CHANNEL_POWER, 8'h03);
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(ADDR_CHANNEL_POWER);
    check("rst_ctrl", rd, 0);
    rd_reg(ADDR_RESULT_HIGH);
    check("rst_keep", rd, 32'h0000_00FF);
    test_done();
  end

  initial begin
    repeat (80000) @(posedge ref_clk_i);
    num_errors++;
    test_done();
  end
endmodule : adc_control_and_result_regs_bench

// ===== test/sar_core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// input mux and sar core stand-in
// ---------------------------------------------------------------
module sar_core_model (
  input wire logic ref_clk_i,
  input wire logic power_i,
  input wire logic [11:0] trial_i,
  input wire logic [11:0] target_i,
  input wire logic negative_i,
  output logic comparator_o,
  output logic result_negative_o
);
  logic noise = 1'b0;
  // unpowered core shows a changing level, never a held value
  always @(posedge ref_clk_i) begin
    noise <= ~noise;
  end
  // keep the trial bit while the trial does not exceed the input
  assign comparator_o = power_i ? (trial_i <= target_i) : noise;
  assign result_negative_o = power_i ? negative_i : noise;
endmodule : sar_core_model
